// [rtl/dual_port_io.sv]
// Two general purpose ports with halt control, alternate functions and register decode.
//
// Overview of operation
// R1: Port L config/data select float, weak pull-up, drive low or drive high.
// R2: Port L data register at 00D0, configuration register at 00D1.
// R3: Reading 00D2 returns the current port L pin levels.
// R4: Port G has six bidirectional pins 0..5 and input-only pins 6, 7.
// R5: Port G bits use the same config/data encoding as port L.
// R6: Port G data at 00D4, configuration at 00D5, pin levels at 00D6.
// R7: Port G bit six and seven config writes ignored, read back zero.
// R8: Writing one to port G data bit seven enters halt.
// R9: While halted all internal state holds its value; here only register writes and reads freeze.
// R10: A rising edge on the wake pin ends halt; not usable with crystal.
// R11: Reset low ends halt.
// R12: During reset ports float; program counter, status and control clear.
// R13: Reset clears data and configuration registers of both ports.
// R14: Port G alternates: interrupt, timer, serial out, clock, in, oscillator/wake.
// R15: Bit seven is oscillator output by option, otherwise input and wake.
// R16: Interrupt enabled by status register 00EF; timer and serial by control 00EE.
// R17: Every port register bit can be set, cleared or tested individually.
// R18: Software places two no-operations after the halt-entry write.
// R19: Pin wake restarts clocks, resumes, and clears the halt request bit.
`timescale 1ns/1ps
module dual_port_io
    import dual_port_pkg::*;
#(
    parameter bit CrystalOption = 1'b0
)
(
    input wire logic clk,
    input wire logic rst,
    input wire dual_port_pkg::addr_type busAddr,
    input wire dual_port_pkg::byte_type busWriteData,
    input wire logic busWrite,
    input wire logic busRead,
    output dual_port_pkg::byte_type busReadData,
    input wire logic [7:0] portLIn,
    output logic [7:0] portLOut,
    output logic [7:0] portLOe,
    output logic [7:0] portLPullUp,
    input wire logic [7:0] portGIn,
    output logic [5:0] portGOut,
    output logic [5:0] portGOe,
    output logic [7:0] portGPullUp,
    input wire logic serialOut,
    input wire logic serialClockOut,
    input wire logic timerOut,
    output logic serialIn,
    output logic serialClockIn,
    output logic timerIn,
    output logic externalIntr,
    output dual_port_pkg::byte_type peripheralControl,
    output dual_port_pkg::byte_type processorStatusWord,
    output logic clockGate,
    output logic haltActive
);
    import dual_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and synchronised pins.
    byte_type lData_q;
    byte_type lConfig_q;
    byte_type gData_q;
    byte_type gConfig_q;
    byte_type control_q;
    byte_type status_q;
    byte_type readData_q;
    halt_state_type haltState_q;
    logic wakePrev_q;
    byte_type lPins;
    byte_type gPins;
    logic wakeRise;
    logic halted;
    logic haltNext;
    pin_sync_if syncBus();

    assign syncBus.raw = {portGIn, portLIn};
    assign lPins = syncBus.clean[7:0];
    assign gPins = syncBus.clean[15:8];

    pin_sync syncUnit
    (
        .clk(clk),
        .rst(rst),
        .syncPort(syncBus)
    );

    function automatic logic addrHit(input addr_type a, input addr_type target);
        addrHit = (a == target);
    endfunction

    assign halted = (haltState_q == HALT_STATE);
    assign wakeRise = gPins[HaltBit] & ~wakePrev_q & ~CrystalOption; // see R10 R15
    assign haltNext = (haltState_q == RUN_STATE && gData_q[HaltBit]) || (halted && !wakeRise); // see R8 R10

    ////////////////////////////////////////////////////////////////////////////////
    // Halt state machine.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            haltState_q <= RUN_STATE; // see R11
        end
        else
        begin
            case (haltState_q)
                RUN_STATE:
                begin
                    if (gData_q[HaltBit])
                    begin
                        haltState_q <= HALT_STATE; // see R8
                    end
                end
                HALT_STATE:
                begin
                    if (wakeRise)
                    begin
                        haltState_q <= WAKE_STATE; // see R10
                    end
                end
                WAKE_STATE:
                begin
                    haltState_q <= RUN_STATE; // see R19
                end
                default:
                begin
                    haltState_q <= RUN_STATE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wakePrev_q <= 1'b0;
        end
        else
        begin
            wakePrev_q <= gPins[HaltBit];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Port registers; writes are frozen while halted.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lData_q <= ResetZero; // see R13
            lConfig_q <= ResetZero; // see R13
        end
        else if (busWrite && !halted) // see R9
        begin
            if (addrHit(busAddr, AddrLData)) // see R2
            begin
                lData_q <= busWriteData; // see R17
            end
            if (addrHit(busAddr, AddrLConfig)) // see R2
            begin
                lConfig_q <= busWriteData;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gData_q <= ResetZero; // see R13
            gConfig_q <= ResetZero; // see R13
        end
        else if (haltState_q == WAKE_STATE)
        begin
            gData_q[HaltBit] <= 1'b0; // see R19
        end
        else if (busWrite && !halted) // see R9
        begin
            if (addrHit(busAddr, AddrGData)) // see R6
            begin
                gData_q <= busWriteData; // see R17
            end
            if (addrHit(busAddr, AddrGConfig)) // see R6
            begin
                gConfig_q <= busWriteData & GConfigWritable; // see R7
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            control_q <= ResetZero; // see R12
            status_q <= ResetZero; // see R12
        end
        else if (busWrite && !halted)
        begin
            if (addrHit(busAddr, AddrControl)) // see R16
            begin
                control_q <= busWriteData;
            end
            if (addrHit(busAddr, AddrStatus)) // see R16
            begin
                status_q <= busWriteData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            readData_q <= ResetZero;
        end
        else if (busRead && !halted)
        begin
            case (busAddr)
                AddrLData: readData_q <= lData_q;
                AddrLConfig: readData_q <= lConfig_q;
                AddrLPins: readData_q <= lPins; // see R3
                AddrGData: readData_q <= gData_q;
                AddrGConfig: readData_q <= gConfig_q & GConfigWritable; // see R7
                AddrGPins: readData_q <= gPins; // see R6
                AddrControl: readData_q <= control_q;
                AddrStatus: readData_q <= status_q;
                default: readData_q <= ResetZero;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pad decode and registered outputs.
    logic [7:0] lLevel;
    logic [7:0] lEnable;
    logic [7:0] lPull;
    logic [7:0] gLevel;
    logic [7:0] gEnable;
    logic [7:0] gPull;
    logic [7:0] gLevelMux;

    pad_setup lPads
    (
        .config_i(lConfig_q),
        .data_i(lData_q),
        .driveLevel(lLevel),
        .driveEnable(lEnable),
        .pullUpEnable(lPull)
    );

    pad_setup gPads
    (
        .config_i(gConfig_q),
        .data_i(gData_q),
        .driveLevel(gLevel),
        .driveEnable(gEnable),
        .pullUpEnable(gPull)
    );

    always_comb
    begin
        gLevelMux = gLevel;
        if (control_q[CtlSerialSelBit]) // see R14
        begin
            gLevelMux[SerOutBit] = serialOut;
            gLevelMux[SerClkBit] = serialClockOut;
        end
        if (control_q[CtlTimerEnBit]) // see R14
        begin
            gLevelMux[TimerBit] = timerOut;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            portLOut <= ResetZero; // see R12
            portLOe <= ResetZero; // see R12
            portLPullUp <= ResetZero;
            portGOut <= 6'h00;
            portGOe <= 6'h00; // see R12
            portGPullUp <= ResetZero;
        end
        else
        begin
            portLOut <= lLevel; // see R1
            portLOe <= lEnable; // see R1
            portLPullUp <= lPull; // see R1
            portGOut <= gLevelMux[5:0]; // see R4
            portGOe <= gEnable[5:0]; // see R5
            portGPullUp <= gPull; // see R5
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            serialIn <= 1'b0;
            serialClockIn <= 1'b0;
            timerIn <= 1'b0;
            externalIntr <= 1'b0;
            clockGate <= 1'b1;
            haltActive <= 1'b0;
        end
        else
        begin
            serialIn <= gPins[SerInBit]; // see R14
            serialClockIn <= gPins[SerClkBit];
            timerIn <= gPins[TimerBit];
            externalIntr <= gPins[IntrBit] & status_q[StatIntrEnBit]; // see R16
            clockGate <= ~haltNext; // see R9
            haltActive <= haltNext; // see R8
        end
    end

    assign busReadData = readData_q;
    assign peripheralControl = control_q;
    assign processorStatusWord = status_q;
endmodule

// [rtl/dual_port_pkg.sv]
// Package with register addresses, field positions and reset values of the dual port block.
package dual_port_pkg;
    localparam int DataWidth = 8;
    localparam int AddrWidth = 16;
    localparam logic [AddrWidth-1:0] AddrLData = 16'h00D0;
    localparam logic [AddrWidth-1:0] AddrLConfig = 16'h00D1;
    localparam logic [AddrWidth-1:0] AddrLPins = 16'h00D2;
    localparam logic [AddrWidth-1:0] AddrGData = 16'h00D4;
    localparam logic [AddrWidth-1:0] AddrGConfig = 16'h00D5;
    localparam logic [AddrWidth-1:0] AddrGPins = 16'h00D6;
    localparam logic [AddrWidth-1:0] AddrControl = 16'h00EE;
    localparam logic [AddrWidth-1:0] AddrStatus = 16'h00EF;
    localparam logic [DataWidth-1:0] ResetZero = 8'h00;
    localparam logic [DataWidth-1:0] GConfigWritable = 8'h3F;
    localparam int HaltBit = 7;
    localparam int IntrBit = 0;
    localparam int TimerBit = 3;
    localparam int SerOutBit = 4;
    localparam int SerClkBit = 5;
    localparam int SerInBit = 6;
    localparam int CtlSerialSelBit = 1;
    localparam int CtlTimerEnBit = 4;
    localparam int StatIntrEnBit = 1;
    localparam int SyncStages = 2;
    typedef logic [DataWidth-1:0] byte_type;
    typedef logic [AddrWidth-1:0] addr_type;
    typedef enum logic [2:0]
    {
        RUN_STATE = 3'b001,
        HALT_STATE = 3'b010,
        WAKE_STATE = 3'b100
    } halt_state_type;
endpackage

// [rtl/pin_sync_if.sv]
// Interface carrying raw pins into the synchroniser and clean levels back out.
`timescale 1ns/1ps
interface pin_sync_if;
    logic [15:0] raw;
    logic [15:0] clean;
    modport source
    (
        output raw,
        input clean
    );
    modport sync
    (
        input raw,
        output clean
    );
endinterface

// [rtl/pin_sync.sv]
// Two flip-flop synchroniser for the sixteen port input pins.
`timescale 1ns/1ps
module pin_sync
    import dual_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    pin_sync_if.sync syncPort
);
    logic [15:0] stageOne_q;
    logic [15:0] stageTwo_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stageOne_q <= 16'h0000;
            stageTwo_q <= 16'h0000;
        end
        else
        begin
            stageOne_q <= syncPort.raw;
            stageTwo_q <= stageOne_q;
        end
    end

    assign syncPort.clean = stageTwo_q;
endmodule

// [rtl/pad_setup.sv]
// Decoder turning configuration and data bytes into pad drive, enable and pull-up controls.
`timescale 1ns/1ps
module pad_setup
    import dual_port_pkg::*;
(
    input wire dual_port_pkg::byte_type config_i,
    input wire dual_port_pkg::byte_type data_i,
    output logic [7:0] driveLevel,
    output logic [7:0] driveEnable,
    output logic [7:0] pullUpEnable
);
    // Config 0/data 0 floats, 0/1 pulls up, 1/x drives the data level.
    always_comb
    begin
        driveEnable = config_i;
        driveLevel = data_i;
        pullUpEnable = ~config_i & data_i;
    end
endmodule

// [sim/dual_port_io_sva.sv]
// Checker of reset, halt, decode and alternate function behaviour at the block's ports.
`timescale 1ns/1ps
module dual_port_io_sva
    import dual_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire dual_port_pkg::addr_type busAddr,
    input wire dual_port_pkg::byte_type busWriteData,
    input wire logic busWrite,
    input wire logic busRead,
    input wire dual_port_pkg::byte_type busReadData,
    input wire logic [7:0] portLOe,
    input wire logic [7:0] portLPullUp,
    input wire logic [5:0] portGOut,
    input wire logic [5:0] portGOe,
    input wire logic [7:0] portGPullUp,
    input wire logic serialOut,
    input wire logic timerOut,
    input wire logic externalIntr,
    input wire dual_port_pkg::byte_type peripheralControl,
    input wire dual_port_pkg::byte_type processorStatusWord,
    input wire logic clockGate,
    input wire logic haltActive
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_clear: assert property ($fell(rst) |-> portLOe == 0 && portGOe == 0 && portLPullUp == 0
        && portGPullUp == 0 && peripheralControl == 0 && processorStatusWord == 0 && !haltActive && clockGate)
        else $error("Outputs not cleared by reset.");
    a_halt_entry: assert property (!haltActive && clockGate && busWrite && busAddr == AddrGData
        && busWriteData[HaltBit] |-> ##[1:3] haltActive) else $error("Halt not entered.");
    a_gate_halt: assert property (!clockGate |-> haltActive) else $error("Clocks gated without halt.");
    a_halt_freeze: assert property (!clockGate && busWrite |=> $stable(peripheralControl)
        && $stable(processorStatusWord)) else $error("Register changed while halted.");
    a_read_unmapped: assert property (busRead && clockGate && busAddr[15:8] != 8'h00
        |=> busReadData == 8'h00) else $error("Unmapped read not zero.");
    a_read_control: assert property (busRead && clockGate && busAddr == AddrControl
        |=> busReadData == $past(peripheralControl)) else $error("Control read wrong.");
    a_intr_gate: assert property (!processorStatusWord[StatIntrEnBit] |=> !externalIntr)
        else $error("Interrupt passed while disabled.");
    a_serial_mux: assert property (peripheralControl[CtlSerialSelBit]
        |=> portGOut[SerOutBit] == $past(serialOut)) else $error("Serial output not routed.");
    a_timer_mux: assert property (peripheralControl[CtlTimerEnBit]
        |=> portGOut[TimerBit] == $past(timerOut)) else $error("Timer output not routed.");
    c_halt: cover property ($fell(clockGate));
    c_wake: cover property ($rose(clockGate));
    c_intr: cover property (externalIntr);
endmodule

// [sim/pin_world.sv]
// Model of outside circuitry that drives, pulls or leaves floating each port pin.
`timescale 1ns/1ps
module pin_world
(
    input wire logic clk,
    input wire logic [7:0] lOut,
    input wire logic [7:0] lOe,
    input wire logic [7:0] lPull,
    input wire logic [5:0] gOut,
    input wire logic [5:0] gOe,
    input wire logic [7:0] gPull,
    input wire logic [7:0] lExt,
    input wire logic [7:0] lDrive,
    input wire logic [7:0] gExt,
    input wire logic [7:0] gDrive,
    output logic [7:0] lPin,
    output logic [7:0] gPin
);
    // A floating pin toggles every cycle so no stale level is ever read.
    logic flip = 1'b0;
    always @(posedge clk) flip <= ~flip;
    function automatic logic [7:0] level(input logic [7:0] o, oe, pu, e, dr, input logic f);
        return (oe & o) | (~oe & dr & e) | (~oe & ~dr & pu) | (~oe & ~dr & ~pu & {8{f}});
    endfunction
    assign lPin = level(lOut, lOe, lPull, lExt, lDrive, flip);
    assign gPin = level({2'b00, gOut}, {2'b00, gOe}, gPull, gExt, gDrive, flip);
endmodule

// [sim/dual_port_io_with_halt_bench.sv]
// Self-checking bench of the dual port block with halt control.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module dual_port_io_with_halt_bench;
    import dual_port_pkg::*;
    typedef struct packed {addr_type a; byte_type w; byte_type r;} row_type;
    logic clk = 1'b0;
    logic rst = 1'b1;
    addr_type busAddr = 16'h0000;
    byte_type busWriteData = 8'h00;
    logic busWrite = 1'b0;
    logic busRead = 1'b0;
    byte_type busReadData, peripheralControl, processorStatusWord;
    logic [7:0] portLIn, portLOut, portLOe, portLPullUp, portGIn, portGPullUp;
    logic [5:0] portGOut, portGOe;
    logic serialOut = 1'b1;
    logic serialClockOut = 1'b0;
    logic timerOut = 1'b0;
    logic serialIn, serialClockIn, timerIn, externalIntr, clockGate, haltActive;
    byte_type lExt = 8'h40;
    byte_type lDrive = 8'h42;
    byte_type gExt = 8'h40;
    byte_type gDrive = 8'hC0;
    int failures = 0;
    int totalChecks = 0;
    int cycles = 0;
    row_type rows [6] = '{'{16'h00D0, 8'hA5, 8'hA5}, '{16'h00D1, 8'h3C, 8'h3C}, '{16'h00D4, 8'h15, 8'h15},
        '{16'h00D5, 8'hFF, 8'h3F}, '{16'h00EE, 8'hED, 8'hED}, '{16'h00EF, 8'hFD, 8'hFD}};
    dual_port_io dut_u (.clk(clk), .rst(rst), .busAddr(busAddr), .busWriteData(busWriteData), .busWrite(busWrite),
        .busRead(busRead), .busReadData(busReadData), .portLIn(portLIn), .portLOut(portLOut), .portLOe(portLOe),
        .portLPullUp(portLPullUp), .portGIn(portGIn), .portGOut(portGOut), .portGOe(portGOe),
        .portGPullUp(portGPullUp), .serialOut(serialOut), .serialClockOut(serialClockOut), .timerOut(timerOut),
        .serialIn(serialIn), .serialClockIn(serialClockIn), .timerIn(timerIn), .externalIntr(externalIntr),
        .peripheralControl(peripheralControl), .processorStatusWord(processorStatusWord), .clockGate(clockGate),
        .haltActive(haltActive));
    pin_world world_u (.clk(clk), .lOut(portLOut), .lOe(portLOe), .lPull(portLPullUp), .gOut(portGOut),
        .gOe(portGOe), .gPull(portGPullUp), .lExt(lExt), .lDrive(lDrive), .gExt(gExt), .gDrive(gDrive),
        .lPin(portLIn), .gPin(portGIn));
    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (failures == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            conclude();
        end
    end
    task automatic wr(input addr_type a, input byte_type d);
        @(posedge clk);
        busAddr <= a;
        busWriteData <= d;
        busWrite <= 1'b1;
        @(posedge clk);
        busWrite <= 1'b0;
    endtask
    task automatic chkRd(input addr_type a, input byte_type e);
        @(posedge clk);
        busAddr <= a;
        busRead <= 1'b1;
        @(posedge clk);
        busRead <= 1'b0;
        #1 `CHK("read", e, busReadData)
    endtask
    function automatic byte_type pins(input byte_type c, d, m, e);
        return (c & d) | (~c & m & e) | (~c & ~m & d);
    endfunction
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        idle(8);
        `CHK("floatL", 8'h00, portLOe | portLPullUp)
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            chkRd(rows[i].a, 8'h00);
            wr(rows[i].a, rows[i].w);
            chkRd(rows[i].a, rows[i].r);
        end
        idle(6);
        `CHK("oeL", 8'h3C, portLOe)
        `CHK("pullL", 8'h81, portLPullUp)
        `CHK("outL", 8'h24, portLOut & portLOe)
        `CHK("oeG", 6'h3F, portGOe)
        `CHK("outG", 6'h15, portGOut)
        chkRd(16'h00D2, pins(8'h3C, 8'hA5, lDrive, lExt));
        chkRd(16'h00D6, pins(8'h3F, 8'h15, gDrive, gExt));
        chkRd(16'h00D3, 8'h00);
        chkRd(16'h01D0, 8'h00);
        wr(16'h00EF, 8'h02);
        idle(6);
        `CHK("intrOn", 1'b1, externalIntr)
        wr(16'h00EF, 8'h00);
        idle(6);
        `CHK("intrOff", 1'b0, externalIntr)
        @(posedge clk);
        serialOut <= 1'b0;
        serialClockOut <= 1'b1;
        wr(16'h00EE, 8'h02);
        idle(6);
        `CHK("serOut", 1'b0, portGOut[SerOutBit])
        `CHK("serClkOut", 1'b1, portGOut[SerClkBit])
        `CHK("serClkIn", 1'b1, serialClockIn)
        `CHK("serIn", 1'b1, serialIn)
        wr(16'h00EE, 8'h00);
        wr(16'h00D4, 8'h95);
        idle(2);
        `CHK("halt", 2'b10, {haltActive, clockGate})
        `CHK("pullG", 8'h80, portGPullUp)
        wr(16'h00EE, 8'h33);
        gExt <= 8'hC0;
        for (int i = 0; i < 20 && clockGate !== 1'b1; i++) @(posedge clk);
        idle(2);
        `CHK("wake", 2'b01, {haltActive, clockGate})
        chkRd(16'h00D4, 8'h15);
        chkRd(16'h00EE, 8'h00);
        wr(16'h00EE, 8'h10);
        timerOut <= 1'b1;
        idle(6);
        `CHK("timerOut", 1'b1, portGOut[TimerBit])
        `CHK("timerIn", 1'b1, timerIn)
        gExt <= 8'h40;
        wr(16'h00D4, 8'h80);
        idle(3);
        `CHK("halt2", 1'b1, haltActive)
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        idle(1);
        `CHK("rstWake", 2'b01, {haltActive, clockGate})
        chkRd(16'h00D5, 8'h00);
        chkRd(16'h00D0, 8'h00);
        conclude();
    end
endmodule
bind dual_port_io dual_port_io_sva chk_u (.clk(clk), .rst(rst), .busAddr(busAddr), .busWriteData(busWriteData),
    .busWrite(busWrite), .busRead(busRead), .busReadData(busReadData), .portLOe(portLOe), .portLPullUp(portLPullUp),
    .portGOut(portGOut), .portGOe(portGOe), .portGPullUp(portGPullUp), .serialOut(serialOut), .timerOut(timerOut),
    .externalIntr(externalIntr), .peripheralControl(peripheralControl), .processorStatusWord(processorStatusWord),
    .clockGate(clockGate), .haltActive(haltActive));
